/* File: hw/pwm_auto_mode_switch_config.sv */
// Configuration, auto-switch and readback logic of one modulator channel.
// Assumes bus, fault and waveform inputs are synchronous to clk_sys.
`timescale 1ns/1ps
// Summary of operation
// R1: no switching inside high threshold band
// R2: no switching inside low threshold band
// R3: threshold low four bits fixed, ignored
// R4: B routing picks one of nine sources
// R5: A routing uses same nine codes
// R6: C output fault effect is gated
// R7: A/B outputs fault effect is gated
// R8: normal mode: advanced bit enables limiting
// R9: multi/resonant: advanced bit enables pulse matching
// R10: resonant fixed duty from high threshold
// R11: mode field selects operating mode
// R12: accelerator enable selects waveform source
// R13: firmware sets edge enable when combining
// R14: three-bit codes select triggering edges
// R15: received filter duty is readable
// R16: limit event captures counter value
// R17: flag gated by enable, rising clear
// R18: region picks max or mid word
module pwm_auto_mode_switch_config (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst, // Async reset, high
  input wire pwm_cfg_pkg::bus_req_t bus_req, // Register request
  output logic [31:0] rdata, // Read data, cycle after read
  input wire logic [17:0] filter_duty, // Duty from filter
  input wire logic [13:0] counter_value, // Modulator counter
  input wire logic cycle_by_cycle_limit, // Limit event pulse
  input wire pwm_cfg_pkg::route_src_t src_a, // A routing sources
  input wire pwm_cfg_pkg::route_src_t src_b, // B routing sources
  input wire logic [3:0] edge_lvl, // Own A, own B, below A, below B
  output pwm_cfg_pkg::cfg_t cfg_out, // Active configuration
  output pwm_cfg_pkg::region_t region, // Operating region
  output logic route_a_out, // Routed A
  output logic route_b_out, // Routed B
  output logic limit_to_c, // Fault acts on C
  output logic limit_to_ab, // Fault acts on A and B
  output logic limit_enable, // Current limiting on
  output logic pulse_match, // A/B pulse matching on
  output logic [17:0] duty_out, // Duty in use
  output logic accelerator_select, // Waveform from accelerator
  output logic edge_gen_enable, // Edge generator enabled
  output logic [3:0] edge_trig, // A on, A off, B on, B off
  output logic irq // Interrupt, level
);
  typedef struct packed {
    logic [3:0][13:0] thr;
    logic [31:0] max_cfg;
    logic [31:0] mid_cfg;
    logic [31:0] edge_ctrl;
    logic [13:0] loc;
    logic [1:0] status;
    logic [1:0] mask;
    logic [1:0] ctrl;
    logic clr_prev;
    logic [3:0] prev_lvl;
    logic [31:0] rdata;
    pwm_cfg_pkg::cfg_t cfg;
    logic route_a;
    logic route_b;
    logic limit_to_c;
    logic limit_to_ab;
    logic limit_enable;
    logic pulse_match;
    logic [17:0] duty;
    logic [3:0] trig;
    logic irq;
  } state_t;
  localparam state_t ST_RESET = '{edge_ctrl: pwm_cfg_pkg::EDGE_RESET, default: '0};
  state_t r;
  state_t next_r;
  pwm_cfg_pkg::cfg_t act_cfg;
  logic switched;
  logic mux_a;
  logic mux_b;
  logic [7:0] edge_vec;
  logic [3:0] trig_now;

  pwm_region_tracker u_track (
    .clk_sys(clk_sys),
    .rst(rst),
    .value(filter_duty[17:4]),
    .hi_up(r.thr[pwm_cfg_pkg::THR_HU]),
    .hi_low(r.thr[pwm_cfg_pkg::THR_HL]),
    .lo_up(r.thr[pwm_cfg_pkg::THR_LU]),
    .lo_low(r.thr[pwm_cfg_pkg::THR_LL]),
    .region(region),
    .switched(switched)
  );

  // R18: upper region takes the max word
  assign act_cfg = (region == pwm_cfg_pkg::REGION_MAX) ?
    pwm_cfg_pkg::cfg_from_word(r.max_cfg) : pwm_cfg_pkg::cfg_from_word(r.mid_cfg);

  // R5: A routing ahead of fine stage
  pwm_route_mux u_mux_a (
    .sel(act_cfg.a_route),
    .src(src_a),
    .out(mux_a)
  );
  // R4: B routing after edge generation
  pwm_route_mux u_mux_b (
    .sel(act_cfg.b_route),
    .src(src_b),
    .out(mux_b)
  );

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_edge
      assign edge_vec[2*k] = edge_lvl[k] & ~r.prev_lvl[k];
      assign edge_vec[2*k+1] = ~edge_lvl[k] & r.prev_lvl[k];
      // R14: edge code picks one trigger
      assign trig_now[k] = r.edge_ctrl[pwm_cfg_pkg::EDGE_EN_BIT] &
        edge_vec[r.edge_ctrl[(pwm_cfg_pkg::EDGE_SEL_TOP_LSB - pwm_cfg_pkg::EDGE_SEL_STEP*k)
          +: pwm_cfg_pkg::EDGE_SEL_W]];
    end
  endgenerate

  always_comb
  begin
    logic [1:0] clr;
    logic [1:0] set;
    clr = '0;
    set = '0;
    next_r = r;
    next_r.rdata = '0;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        // R3: only the coarse bits store
        pwm_cfg_pkg::OFS_HI_UP:
          next_r.thr[pwm_cfg_pkg::THR_HU] = bus_req.wdata[17:4];
        pwm_cfg_pkg::OFS_HI_LOW:
          next_r.thr[pwm_cfg_pkg::THR_HL] = bus_req.wdata[17:4];
        pwm_cfg_pkg::OFS_LO_UP:
          next_r.thr[pwm_cfg_pkg::THR_LU] = bus_req.wdata[17:4];
        pwm_cfg_pkg::OFS_LO_LOW:
          next_r.thr[pwm_cfg_pkg::THR_LL] = bus_req.wdata[17:4];
        pwm_cfg_pkg::OFS_MAX_CFG:
          next_r.max_cfg = bus_req.wdata & pwm_cfg_pkg::CFG_WMASK;
        pwm_cfg_pkg::OFS_MID_CFG:
          next_r.mid_cfg = bus_req.wdata & pwm_cfg_pkg::CFG_WMASK;
        pwm_cfg_pkg::OFS_EDGE:
          next_r.edge_ctrl = bus_req.wdata & pwm_cfg_pkg::EDGE_WMASK;
        pwm_cfg_pkg::OFS_STATUS:
          clr = bus_req.wdata[1:0];
        pwm_cfg_pkg::OFS_MASK:
          next_r.mask = bus_req.wdata[1:0];
        pwm_cfg_pkg::OFS_CTRL:
          next_r.ctrl = bus_req.wdata[1:0];
        default: next_r.ctrl = r.ctrl;
      endcase
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        // R3: low bits read fixed
        pwm_cfg_pkg::OFS_HI_UP:
          next_r.rdata = {14'h0000, r.thr[pwm_cfg_pkg::THR_HU], pwm_cfg_pkg::THR_FIXED_LSBS};
        pwm_cfg_pkg::OFS_HI_LOW:
          next_r.rdata = {14'h0000, r.thr[pwm_cfg_pkg::THR_HL], pwm_cfg_pkg::THR_FIXED_LSBS};
        pwm_cfg_pkg::OFS_LO_UP:
          next_r.rdata = {14'h0000, r.thr[pwm_cfg_pkg::THR_LU], pwm_cfg_pkg::THR_FIXED_LSBS};
        pwm_cfg_pkg::OFS_LO_LOW:
          next_r.rdata = {14'h0000, r.thr[pwm_cfg_pkg::THR_LL], pwm_cfg_pkg::THR_FIXED_LSBS};
        pwm_cfg_pkg::OFS_MAX_CFG:
          next_r.rdata = r.max_cfg;
        pwm_cfg_pkg::OFS_MID_CFG:
          next_r.rdata = r.mid_cfg;
        pwm_cfg_pkg::OFS_EDGE:
          next_r.rdata = r.edge_ctrl;
        // R15: duty view straight from filter
        pwm_cfg_pkg::OFS_DUTY:
          next_r.rdata = {14'h0000, filter_duty};
        pwm_cfg_pkg::OFS_LOC:
          next_r.rdata = {18'h00000, r.loc};
        pwm_cfg_pkg::OFS_STATUS:
          next_r.rdata = {30'h00000000, r.status};
        pwm_cfg_pkg::OFS_MASK:
          next_r.rdata = {30'h00000000, r.mask};
        pwm_cfg_pkg::OFS_CTRL:
          next_r.rdata = {30'h00000000, r.ctrl};
        default: next_r.rdata = '0;
      endcase
    end
    // R16: capture counter on limit event
    if (cycle_by_cycle_limit)
      next_r.loc = counter_value;
    // R17: flag gated, cleared on rising clear
    next_r.clr_prev = r.ctrl[pwm_cfg_pkg::CTRL_FLAG_CLR];
    if (r.ctrl[pwm_cfg_pkg::CTRL_FLAG_CLR] && !r.clr_prev)
      clr[pwm_cfg_pkg::ST_MODE_SW] = 1'b1;
    set[pwm_cfg_pkg::ST_MODE_SW] = switched & r.ctrl[pwm_cfg_pkg::CTRL_FLAG_EN];
    set[pwm_cfg_pkg::ST_LIMIT] = cycle_by_cycle_limit;
    next_r.status = (r.status & ~clr) | set;
    next_r.irq = |(next_r.status & next_r.mask);
    next_r.cfg = act_cfg;
    next_r.route_a = mux_a;
    next_r.route_b = mux_b;
    // R6: fault reaches C only when enabled
    next_r.limit_to_c = cycle_by_cycle_limit & act_cfg.limit_affects_c_output;
    // R7: fault reaches A/B only when enabled
    next_r.limit_to_ab = cycle_by_cycle_limit & act_cfg.limit_affects_ab_outputs;
    // R8: R11: limiting in normal mode
    next_r.limit_enable = act_cfg.limit_or_pulse_match_enable &
      (act_cfg.mode == pwm_cfg_pkg::MODE_NORMAL);
    // R9: pulse matching in multi or resonant
    next_r.pulse_match = act_cfg.limit_or_pulse_match_enable &
      ((act_cfg.mode == pwm_cfg_pkg::MODE_MULTI) || (act_cfg.mode == pwm_cfg_pkg::MODE_RESONANT));
    // R10: fixed duty from high threshold
    if (act_cfg.resonant_fixed_duty_enable && (act_cfg.mode == pwm_cfg_pkg::MODE_RESONANT))
      next_r.duty = {r.thr[pwm_cfg_pkg::THR_HU], pwm_cfg_pkg::THR_FIXED_LSBS};
    else
      next_r.duty = filter_duty;
    next_r.prev_lvl = edge_lvl;
    next_r.trig = trig_now;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) r <= ST_RESET;
    else r <= next_r;
  end

  assign rdata = r.rdata;
  assign cfg_out = r.cfg;
  assign route_a_out = r.route_a;
  assign route_b_out = r.route_b;
  assign limit_to_c = r.limit_to_c;
  assign limit_to_ab = r.limit_to_ab;
  assign limit_enable = r.limit_enable;
  assign pulse_match = r.pulse_match;
  assign duty_out = r.duty;
  // R12: accelerator source select
  assign accelerator_select = r.cfg.accelerator_input_enable;
  // R13: edge enable as firmware set it
  assign edge_gen_enable = r.edge_ctrl[pwm_cfg_pkg::EDGE_EN_BIT];
  assign edge_trig = r.trig;
  assign irq = r.irq;

  property p_hi_band;
    @(posedge clk_sys) disable iff (rst)
    (region == pwm_cfg_pkg::REGION_MAX) && (filter_duty[17:4] >= r.thr[pwm_cfg_pkg::THR_HL])
    |=> (region == pwm_cfg_pkg::REGION_MAX);
  endproperty
  a_hi_band: assert property (p_hi_band) // R1
    else $error("left max inside high band");

  property p_lo_band;
    @(posedge clk_sys) disable iff (rst)
    (region == pwm_cfg_pkg::REGION_LOW) && (filter_duty[17:4] <= r.thr[pwm_cfg_pkg::THR_LU])
    |=> (region == pwm_cfg_pkg::REGION_LOW);
  endproperty
  a_lo_band: assert property (p_lo_band) // R2
    else $error("left low inside low band");

  property p_thr_lsbs;
    @(posedge clk_sys) disable iff (rst)
    bus_req.rd && (bus_req.addr == pwm_cfg_pkg::OFS_HI_UP) |=> (rdata[3:0] == 4'h0);
  endproperty
  a_thr_lsbs: assert property (p_thr_lsbs) // R3
    else $error("threshold low bits not fixed");

  property p_route_b;
    @(posedge clk_sys) disable iff (rst)
    (act_cfg.b_route == pwm_cfg_pkg::ROUTE_CROSS) |=> (route_b_out == $past(src_b.crossover));
  endproperty
  a_route_b: assert property (p_route_b) // R4
    else $error("B crossover not routed");

  property p_route_a;
    @(posedge clk_sys) disable iff (rst)
    (act_cfg.a_route == pwm_cfg_pkg::ROUTE_PASS) |=> (route_a_out == $past(src_a.pass));
  endproperty
  a_route_a: assert property (p_route_a) // R5
    else $error("A pass-through not routed");

  property p_c_gate;
    @(posedge clk_sys) disable iff (rst)
    cycle_by_cycle_limit |=> (limit_to_c == cfg_out.limit_affects_c_output);
  endproperty
  a_c_gate: assert property (p_c_gate) // R6
    else $error("C fault gating wrong");

  property p_ab_gate;
    @(posedge clk_sys) disable iff (rst)
    !cycle_by_cycle_limit |=> !limit_to_ab;
  endproperty
  a_ab_gate: assert property (p_ab_gate) // R7
    else $error("A/B fault effect without event");

  property p_match;
    @(posedge clk_sys) disable iff (rst)
    pulse_match |-> !limit_enable && (cfg_out.mode != pwm_cfg_pkg::MODE_NORMAL);
  endproperty
  a_match: assert property (p_match) // R9
    else $error("pulse match in normal mode");

  property p_fixed;
    @(posedge clk_sys) disable iff (rst)
    act_cfg.resonant_fixed_duty_enable && (act_cfg.mode == pwm_cfg_pkg::MODE_RESONANT)
    |=> (duty_out[17:4] == $past(r.thr[pwm_cfg_pkg::THR_HU]));
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed duty not used"); // R10

  sequence s_event;
    cycle_by_cycle_limit;
  endsequence
  sequence s_read_loc;
    bus_req.rd && (bus_req.addr == pwm_cfg_pkg::OFS_LOC) && !cycle_by_cycle_limit;
  endsequence
  property p_capture;
    @(posedge clk_sys) disable iff (rst)
    s_event ##1 s_read_loc |=> (rdata[13:0] == $past(counter_value, 2));
  endproperty
  a_capture: assert property (p_capture) else $error("counter not captured"); // R16

  property p_flag;
    @(posedge clk_sys) disable iff (rst)
    $rose(r.status[pwm_cfg_pkg::ST_MODE_SW]) |-> $past(r.ctrl[pwm_cfg_pkg::CTRL_FLAG_EN]);
  endproperty
  a_flag: assert property (p_flag) // R17
    else $error("flag raised while disabled");

  property p_limit_on;
    @(posedge clk_sys) disable iff (rst)
    act_cfg.limit_or_pulse_match_enable && (act_cfg.mode == pwm_cfg_pkg::MODE_NORMAL)
    |=> limit_enable;
  endproperty
  a_limit_on: assert property (p_limit_on) // R8
    else $error("limiting not enabled");

  property p_duty_view;
    @(posedge clk_sys) disable iff (rst)
    bus_req.rd && (bus_req.addr == pwm_cfg_pkg::OFS_DUTY)
    |=> (rdata[17:0] == $past(filter_duty));
  endproperty
  a_duty_view: assert property (p_duty_view) // R15
    else $error("duty view wrong");
endmodule

/* File: hw/pwm_cfg_pkg.sv */
// Offsets, field layout, codes and types of the modulator configuration block.
// Assumes a 32-bit register port addressed by byte.
package pwm_cfg_pkg;
  localparam logic [31:0] OFS_HI_UP = 32'h001D0068;
  localparam logic [31:0] OFS_HI_LOW = 32'h001D006C;
  localparam logic [31:0] OFS_LO_UP = 32'h001D0070;
  localparam logic [31:0] OFS_LO_LOW = 32'h001D0074;
  localparam logic [31:0] OFS_MAX_CFG = 32'h001D0078;
  localparam logic [31:0] OFS_MID_CFG = 32'h001D007C;
  localparam logic [31:0] OFS_EDGE = 32'h001D0080;
  localparam logic [31:0] OFS_DUTY = 32'h001D0084;
  localparam logic [31:0] OFS_LOC = 32'h001D0088;
  localparam logic [31:0] OFS_STATUS = 32'h001D008C;
  localparam logic [31:0] OFS_MASK = 32'h001D0090;
  localparam logic [31:0] OFS_CTRL = 32'h001D0094;
  localparam logic [31:0] CFG_WMASK = 32'hFF9810F2;
  localparam logic [31:0] EDGE_WMASK = 32'h00017777;
  localparam logic [31:0] EDGE_RESET = 32'h00000123;
  localparam logic [3:0] THR_FIXED_LSBS = 4'h0;
  localparam int THR_LSB = 4;
  localparam int THR_W = 14;
  localparam int DUTY_W = 18;
  localparam int LOC_W = 14;
  localparam int THR_HU = 0;
  localparam int THR_HL = 1;
  localparam int THR_LU = 2;
  localparam int THR_LL = 3;
  localparam int B_ROUTE_LSB = 28;
  localparam int A_ROUTE_LSB = 24;
  localparam int C_LIMIT_BIT = 23;
  localparam int AB_LIMIT_BIT = 20;
  localparam int ADV_BIT = 19;
  localparam int FIXED_DUTY_BIT = 12;
  localparam int MODE_LSB = 4;
  localparam int ACCEL_BIT = 1;
  localparam int EDGE_EN_BIT = 16;
  localparam int EDGE_SEL_TOP_LSB = 12;
  localparam int EDGE_SEL_STEP = 4;
  localparam int EDGE_SEL_W = 3;
  localparam int ST_MODE_SW = 0;
  localparam int ST_LIMIT = 1;
  localparam int IRQ_W = 2;
  localparam int CTRL_FLAG_EN = 0;
  localparam int CTRL_FLAG_CLR = 1;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_RESONANT = 4'h1;
  localparam logic [3:0] MODE_MULTI = 4'h2;
  localparam logic [3:0] MODE_TRIANGULAR = 4'h3;
  localparam logic [3:0] MODE_LEADING = 4'h4;
  localparam logic [3:0] ROUTE_PASS = 4'h0;
  localparam logic [3:0] ROUTE_EDGE_GEN = 4'h1;
  localparam logic [3:0] ROUTE_OWN_C = 4'h2;
  localparam logic [3:0] ROUTE_CROSS = 4'h3;
  localparam logic [3:0] ROUTE_BELOW_A = 4'h4;
  localparam logic [3:0] ROUTE_BELOW_B = 4'h5;
  localparam logic [3:0] ROUTE_BELOW_C = 4'h6;
  localparam logic [3:0] ROUTE_BELOW_L2C = 4'h7;
  localparam logic [3:0] ROUTE_BELOW_L3C = 4'h8;
  typedef enum logic [2:0] {REGION_LOW = 3'b001, REGION_MID = 3'b010, REGION_MAX = 3'b100} region_t;
  typedef struct packed {
    logic pass; logic edge_gen; logic own_c; logic crossover; logic below_a;
    logic below_b; logic below_c; logic below_l2_c; logic below_l3_c;
  } route_src_t;
  typedef struct packed {
    logic [31:0] addr; logic [31:0] wdata; logic wr; logic rd;
  } bus_req_t;
  typedef struct packed {
    logic [3:0] b_route; logic [3:0] a_route; logic limit_affects_c_output;
    logic limit_affects_ab_outputs; logic limit_or_pulse_match_enable;
    logic resonant_fixed_duty_enable; logic [3:0] mode; logic accelerator_input_enable;
  } cfg_t;
  function automatic cfg_t cfg_from_word(input logic [31:0] w);
    cfg_from_word.b_route = w[B_ROUTE_LSB +: 4];
    cfg_from_word.a_route = w[A_ROUTE_LSB +: 4];
    cfg_from_word.limit_affects_c_output = w[C_LIMIT_BIT];
    cfg_from_word.limit_affects_ab_outputs = w[AB_LIMIT_BIT];
    cfg_from_word.limit_or_pulse_match_enable = w[ADV_BIT];
    cfg_from_word.resonant_fixed_duty_enable = w[FIXED_DUTY_BIT];
    cfg_from_word.mode = w[MODE_LSB +: 4];
    cfg_from_word.accelerator_input_enable = w[ACCEL_BIT];
  endfunction
endpackage

/* File: hw/pwm_route_mux.sv */
// Nine-way selector for one output channel's routing.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pwm_route_mux (
  input wire logic [3:0] sel, // Routing code
  input wire pwm_cfg_pkg::route_src_t src, // Candidate signals
  output logic out // Selected signal
);
  always_comb
  begin
    case (sel)
      pwm_cfg_pkg::ROUTE_PASS: out = src.pass;
      pwm_cfg_pkg::ROUTE_EDGE_GEN: out = src.edge_gen;
      pwm_cfg_pkg::ROUTE_OWN_C: out = src.own_c;
      pwm_cfg_pkg::ROUTE_CROSS: out = src.crossover;
      pwm_cfg_pkg::ROUTE_BELOW_A: out = src.below_a;
      pwm_cfg_pkg::ROUTE_BELOW_B: out = src.below_b;
      pwm_cfg_pkg::ROUTE_BELOW_C: out = src.below_c;
      pwm_cfg_pkg::ROUTE_BELOW_L2C: out = src.below_l2_c;
      pwm_cfg_pkg::ROUTE_BELOW_L3C: out = src.below_l3_c;
      default: out = 1'b0;
    endcase
  end
endmodule

/* File: hw/pwm_region_tracker.sv */
// Hysteresis tracker of the operating region from the controlling value.
// Thresholds come from the register file on the same clock.
`timescale 1ns/1ps
module pwm_region_tracker (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [13:0] value, // Controlling value, coarse
  input wire logic [13:0] hi_up, // High band upper edge
  input wire logic [13:0] hi_low, // High band lower edge
  input wire logic [13:0] lo_up, // Low band upper edge
  input wire logic [13:0] lo_low, // Low band lower edge
  output pwm_cfg_pkg::region_t region, // Current region
  output logic switched // Pulse on region change
);
  typedef struct packed {
    pwm_cfg_pkg::region_t region;
    logic switched;
  } track_t;
  localparam track_t TRACK_RESET = '{region: pwm_cfg_pkg::REGION_MID, switched: 1'b0};
  track_t r;
  track_t next_r;
  always_comb
  begin
    next_r = r;
    case (r.region)
      // R18: leave middle only past a band edge
      pwm_cfg_pkg::REGION_MID:
        if (value > hi_up) next_r.region = pwm_cfg_pkg::REGION_MAX;
        else if (value < lo_low) next_r.region = pwm_cfg_pkg::REGION_LOW;
      // R1: hold inside the high band
      pwm_cfg_pkg::REGION_MAX:
        if (value < hi_low) next_r.region = pwm_cfg_pkg::REGION_MID;
      // R2: hold inside the low band
      pwm_cfg_pkg::REGION_LOW:
        if (value > lo_up) next_r.region = pwm_cfg_pkg::REGION_MID;
      default: next_r.region = pwm_cfg_pkg::REGION_MID;
    endcase
    next_r.switched = (next_r.region != r.region);
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) r <= TRACK_RESET;
    else r <= next_r;
  end
  assign region = r.region;
  assign switched = r.switched;
endmodule

/* File: bench/pwm_far_side_model.sv */
// Far-side stand-in: routing candidates, neighbour edge levels, counter.
// Assumes the bench picks the raised source and the wanted levels.
`timescale 1ns/1ps
module pwm_far_side_model (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [3:0] hot, // Source code to raise
  input wire logic [3:0] lvl, // Wanted edge levels
  output logic [13:0] counter_value, // Free-running count
  output pwm_cfg_pkg::route_src_t src_a, // A candidates
  output pwm_cfg_pkg::route_src_t src_b, // B candidates
  output logic [3:0] edge_lvl // Own and neighbour levels
);
  // At most one source high, so a wrong pick reads low
  assign src_a = pwm_cfg_pkg::route_src_t'(9'h100 >> hot);
  assign src_b = pwm_cfg_pkg::route_src_t'(9'h100 >> hot);
  assign edge_lvl = lvl;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      counter_value <= 14'h0000;
    else
      counter_value <= counter_value + 14'h0005;
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench of the modulator configuration block.
// Assumes the far-side model drives routing, edge levels and the counter.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [31:0] addr; logic [31:0] wdata; logic [31:0] want;} row_t;
  logic clk_sys, rst, lim, seen;
  pwm_cfg_pkg::bus_req_t bus_req;
  logic [31:0] rdata, d;
  logic [17:0] filter_duty, duty_out;
  logic [13:0] counter_value, loc_exp;
  logic [3:0] hot, lvl, edge_trig, edge_lvl;
  pwm_cfg_pkg::route_src_t src_a, src_b;
  pwm_cfg_pkg::cfg_t cfg_out;
  pwm_cfg_pkg::region_t region;
  logic route_a_out, route_b_out, limit_to_c, limit_to_ab, limit_enable, pulse_match;
  logic accelerator_select, edge_gen_enable, irq;
  int n_fail, num_checks;
  row_t rows[9];
  logic [13:0] vals[9] = '{14'h180, 14'h300, 14'h301, 14'h200, 14'h1FF, 14'h080, 14'h07F,
    14'h100, 14'h101};
  logic [2:0] rexp[9] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h2};
  logic [31:0] lwords[3] = '{32'h00000020, 32'h00800020, 32'h00100020};

  pwm_auto_mode_switch_config uut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .filter_duty(filter_duty), .counter_value(counter_value),
    .cycle_by_cycle_limit(lim), .src_a(src_a), .src_b(src_b), .edge_lvl(edge_lvl),
    .cfg_out(cfg_out), .region(region), .route_a_out(route_a_out),
    .route_b_out(route_b_out), .limit_to_c(limit_to_c), .limit_to_ab(limit_to_ab),
    .limit_enable(limit_enable), .pulse_match(pulse_match), .duty_out(duty_out),
    .accelerator_select(accelerator_select), .edge_gen_enable(edge_gen_enable),
    .edge_trig(edge_trig), .irq(irq));
  pwm_far_side_model far (.clk_sys(clk_sys), .rst(rst), .hot(hot), .lvl(lvl),
    .counter_value(counter_value), .src_a(src_a), .src_b(src_b), .edge_lvl(edge_lvl));

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    num_checks++;
    if (got !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    bus_req <= '{a, w, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] r);
    @(posedge clk_sys);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 r = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    filter_duty = 18'h2ABCD;
    lim = 1'b0;
    hot = 4'hF;
    lvl = 4'h0;
    n_fail = 0;
    num_checks = 0;
    rows[0] = '{pwm_cfg_pkg::OFS_HI_UP, 32'hFFFFFFFF, 32'h0003FFF0};
    rows[1] = '{pwm_cfg_pkg::OFS_HI_LOW, 32'h12345678, 32'h00005670};
    rows[2] = '{pwm_cfg_pkg::OFS_LO_UP, 32'hFFFFFFFF, 32'h0003FFF0};
    rows[3] = '{pwm_cfg_pkg::OFS_LO_LOW, 32'h0000000F, 32'h00000000};
    rows[4] = '{pwm_cfg_pkg::OFS_MAX_CFG, 32'hFFFFFFFF, 32'hFF9810F2};
    rows[5] = '{pwm_cfg_pkg::OFS_MID_CFG, 32'hAAAAAAAA, 32'hAA8800A2};
    rows[6] = '{pwm_cfg_pkg::OFS_EDGE, 32'hFFFFFFFF, 32'h00017777};
    rows[7] = '{pwm_cfg_pkg::OFS_DUTY, 32'hFFFFFFFF, 32'h0002ABCD};
    rows[8] = '{32'h001D0098, 32'hFFFFFFFF, 32'h00000000};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      bus_wr(rows[i].addr, rows[i].wdata);
      bus_rd(rows[i].addr, d);
      chk(d, rows[i].want, "readback"); // readback
    end
    $display("register table done");
    bus_wr(pwm_cfg_pkg::OFS_HI_UP, 32'h00003000);
    bus_wr(pwm_cfg_pkg::OFS_HI_LOW, 32'h00002000);
    bus_wr(pwm_cfg_pkg::OFS_LO_UP, 32'h00001000);
    bus_wr(pwm_cfg_pkg::OFS_LO_LOW, 32'h00000800);
    bus_wr(pwm_cfg_pkg::OFS_MAX_CFG, 32'h00000010);
    bus_wr(pwm_cfg_pkg::OFS_MID_CFG, 32'h00000020);
    foreach (vals[i])
    begin
      @(posedge clk_sys);
      filter_duty <= {vals[i], 4'h5};
      wait_cyc(4);
      chk(region, rexp[i], "region"); // hysteresis
      chk(cfg_out.mode, (rexp[i] == 3'h4) ? 32'h1 : 32'h2, "active word"); // word pick
    end
    bus_rd(pwm_cfg_pkg::OFS_STATUS, d);
    chk(d, 32'h0, "flag while disabled"); // gated flag
    bus_wr(pwm_cfg_pkg::OFS_CTRL, 32'h1);
    bus_wr(pwm_cfg_pkg::OFS_MASK, 32'h3);
    @(posedge clk_sys);
    filter_duty <= {14'h301, 4'h0};
    wait_cyc(4);
    chk(irq, 1, "switch irq"); // flag raised
    bus_wr(pwm_cfg_pkg::OFS_CTRL, 32'h3);
    wait_cyc(2);
    bus_rd(pwm_cfg_pkg::OFS_STATUS, d);
    chk(d, 32'h0, "rising clear"); // rising clear
    chk(irq, 0, "irq after clear"); // rising clear
    bus_wr(pwm_cfg_pkg::OFS_CTRL, 32'h1);
    bus_wr(pwm_cfg_pkg::OFS_MASK, 32'h0);
    @(posedge clk_sys);
    filter_duty <= {14'h180, 4'h5};
    wait_cyc(4);
    chk(irq, 0, "masked irq");
    bus_rd(pwm_cfg_pkg::OFS_STATUS, d);
    chk(d, 32'h1, "sticky flag"); // flag raised
    bus_wr(pwm_cfg_pkg::OFS_STATUS, 32'h1);
    bus_rd(pwm_cfg_pkg::OFS_STATUS, d);
    chk(d, 32'h0, "write one clear");
    $display("auto switch done");
    bus_wr(pwm_cfg_pkg::OFS_MASK, 32'h2);
    foreach (lwords[i])
    begin
      bus_wr(pwm_cfg_pkg::OFS_MID_CFG, lwords[i]);
      @(posedge clk_sys);
      lim <= 1'b1;
      @(negedge clk_sys);
      loc_exp = counter_value;
      @(posedge clk_sys);
      lim <= 1'b0;
      bus_req <= '{pwm_cfg_pkg::OFS_LOC, 32'h0, 1'b0, 1'b1};
      @(negedge clk_sys);
      chk(limit_to_c, lwords[i][23], "c gate"); // c gating
      chk(limit_to_ab, lwords[i][20], "ab gate"); // ab gating
      chk(irq, 1, "event irq");
      @(posedge clk_sys);
      bus_req <= '0;
      #1 chk(rdata, {18'h0, loc_exp}, "event count"); // capture
      bus_wr(pwm_cfg_pkg::OFS_STATUS, 32'h2);
      wait_cyc(2);
      chk(irq, 0, "event cleared");
    end
    $display("limit events done");
    for (int c = 0; c < 10; c++)
    begin
      bus_wr(pwm_cfg_pkg::OFS_MID_CFG, {c[3:0], c[3:0], 24'h000020});
      @(posedge clk_sys);
      hot <= c[3:0];
      wait_cyc(3);
      chk(route_a_out, c < 9, "a route"); // a routing
      chk(route_b_out, c < 9, "b route"); // b routing
      @(posedge clk_sys);
      hot <= c[3:0] + 4'h1;
      wait_cyc(3);
      chk({route_a_out, route_b_out}, 32'h0, "other source"); // routing
    end
    $display("routing done");
    for (int m = 0; m < 5; m++)
    begin
      bus_wr(pwm_cfg_pkg::OFS_MID_CFG, 32'h00081000 | 32'(m * 16 + (m % 2) * 2));
      wait_cyc(3);
      chk(cfg_out.mode, m, "mode field"); // mode
      chk(limit_enable, m == 0, "limiting"); // normal mode
      chk(pulse_match, m == 1 || m == 2, "matching"); // pulse match
      chk(duty_out, (m == 1) ? 32'h3000 : 32'h1805, "duty"); // fixed duty
      chk(accelerator_select, m % 2, "accel"); // input source
    end
    $display("modes done");
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(pwm_cfg_pkg::OFS_EDGE, 32'h00010000 | 32'(c * 4096));
      @(posedge clk_sys);
      lvl <= {4{c[0]}};
      repeat (4) @(posedge clk_sys);
      lvl <= {4{c[0]}} ^ (4'h1 << (c / 2));
      seen = 1'b0;
      repeat (4)
      begin
        @(posedge clk_sys);
        #1 seen = seen | edge_trig[0];
      end
      chk(seen, 1, "edge select"); // edge codes
      chk(edge_gen_enable, 1, "edge enable");
    end
    bus_wr(pwm_cfg_pkg::OFS_EDGE, 32'h0);
    @(posedge clk_sys);
    lvl <= 4'h0;
    repeat (4) @(posedge clk_sys);
    lvl <= 4'hF;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1 seen = seen | (|edge_trig);
    end
    chk(seen, 0, "edges while disabled"); // edge enable off
    $display("edge select done");
    @(posedge clk_sys);
    rst <= 1'b1;
    wait_cyc(2);
    chk(region, 3'h2, "reset region");
    chk(irq, 0, "reset irq");
    @(posedge clk_sys);
    rst <= 1'b0;
    bus_rd(pwm_cfg_pkg::OFS_EDGE, d);
    chk(d, pwm_cfg_pkg::EDGE_RESET, "reset edge");
    bus_rd(pwm_cfg_pkg::OFS_MAX_CFG, d);
    chk(d, 32'h0, "reset max word");
    $display("reset done");
    summarize();
  end
endmodule
